// *** shared/clock_ctrl_map.vh ***
// register map, field positions, reset values and timing counts of the clock controller
// Notes on behaviour
// - multipliers stay off until software enables
// - halt returns core, skew, slicer registers
// - core register: enable 7, select 6, factor
// - select ignored, crystal used while disabled
// - crystal drives core after any reset
// - core rate is crystal times (factor+1)/2
// - skew enable at bit 7 supplies dot clock
// - skew bit 6 low halves dot output
// - dot rate is crystal times factor plus one
// - pixel gate bit 7 passes pixel clocks
// - slicer enable bit 7 supplies oversampling clock
// - label slicer clocked only with its enable
// - slicer bit 6 doubles prescale to 128 for 8 MHz
// - slicer multiply 777, prescale 64 or 128
// - video mode bit 4 picks 50/60 Hz slicing
`ifndef CLOCK_CTRL_MAP_VH
`define CLOCK_CTRL_MAP_VH
`define OFS_PIXEL_GATE 8'h00FB
`define OFS_SLICER 8'h00FC
`define OFS_CORE 8'h00FD
`define OFS_SKEW 8'h00FE
`define RST_PIXEL_GATE 8'h0000
`define RST_SLICER 8'h0000
`define RST_CORE 8'h0000
`define RST_SKEW 8'h0000
`define MASK_PIXEL_GATE 8'h0080
`define MASK_SLICER 8'h00D0
`define MASK_CORE 8'h00CF
`define MASK_SKEW 8'h00CF
`define BIT_ENABLE 7
`define BIT_SELECT 6
`define BIT_VIDEO_MODE 4
`define FACTOR_MSB 3
`define SLICER_MULT 10'h0309
`define SLICER_PRESCALE_4M 8'h0040
`define SLICER_PRESCALE_8M 8'h0080
`define BYTES_PER_LINE_50 6'h0029
`define BYTES_PER_LINE_60 6'h0021
`define CORE_SETTLE_MS 35
`define SLICER_SETTLE_MS 200
`endif

// *** hdl/clock_ratio_calc.v ***
// ratio arithmetic for the core and dot multipliers
`timescale 1ns/1ps
`include "clock_ctrl_map.vh"
module clock_ratio_calc (
	input wire [3:0] core_factor,
	input wire [3:0] dot_factor,
	input wire dot_bypass,
	output wire [4:0] core_ratio_x2,
	output wire [4:0] dot_ratio,
	output wire [5:0] dot_out_ratio_x2
);
	// core output is crystal * (factor + 1) / 2, expressed as twice the ratio
	assign core_ratio_x2 = {1'b0, core_factor} + 5'h01;
	// dot clock is crystal * (factor + 1)
	assign dot_ratio = {1'b0, dot_factor} + 5'h01;
	// divider active when bypass is low: output ratio is dot_ratio / 2 (half-units equal dot_ratio), else dot_ratio doubled in half-units
	assign dot_out_ratio_x2 = dot_bypass ? {dot_ratio, 1'b0} : {1'b0, dot_ratio};
endmodule

// *** hdl/timing_clock_multiplier_control.v ***
// register page and clock steering of the timing and clock controller
`timescale 1ns/1ps
`include "clock_ctrl_map.vh"
module timing_clock_multiplier_control (
	// single system clock
	input wire CLK,
	// asynchronous reset, active low
	input wire RST_N,
	// high while the processor enters halt
	input wire HALT_ENTRY,
	// register page access
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [7:0] REG_RDATA,
	// enable bit of the label and signalling slicer, same clock
	input wire LABEL_SLICER_EN,
	// core multiplier controls toward the analog loop and clock switch
	output wire CORE_MULT_ON,
	output wire CORE_USE_MULT,
	output wire [4:0] CORE_RATIO_X2,
	// dot clock multiplier controls
	output wire DOT_MULT_ON,
	output wire DOT_HALF_BYPASS,
	output wire [4:0] DOT_RATIO,
	output wire [5:0] DOT_OUT_RATIO_X2,
	// pixel and display ram clock gate
	output wire PIXEL_CLOCK_PASS,
	// slicer multiplier controls and video mode
	output wire SLICER_MULT_ON,
	output wire LABEL_SLICER_CLOCK_ON,
	output wire [9:0] SLICER_MULT_FACTOR,
	output wire [7:0] SLICER_PRESCALE,
	output wire VIDEO_60HZ,
	output wire [5:0] BYTES_PER_LINE
);
	// register contents, reset to all zeros so every loop is off
	reg [7:0] core_reg; // core_clock_multiplier_ctrl
	reg [7:0] core_next; // core contents after this edge
	reg [7:0] skew_reg; // dot_clock_skew_ctrl
	reg [7:0] skew_next; // skew contents after this edge
	reg [7:0] pixel_reg; // pixel_clock_gate_ctrl
	reg [7:0] pixel_next; // pixel gate contents after this edge
	reg [7:0] slicer_reg; // slicer_clock_ctrl
	reg [7:0] slicer_next; // slicer contents after this edge
	reg [7:0] read_next; // value that a read strobe loads

	// one-hot register pick from the page offset
	wire [3:0] page_hit; // bit 0 pixel, 1 slicer, 2 core, 3 skew
	wire pixel_wr; // write aimed at the pixel gate
	wire slicer_wr; // write aimed at the slicer register
	wire core_wr; // write aimed at the core register
	wire skew_wr; // write aimed at the skew register

	// label slicer enable comes from another block on the same clock, so no synchroniser
	wire core_mult_enable = core_reg[`BIT_ENABLE];
	wire core_clock_select = core_reg[`BIT_SELECT];
	wire dot_mult_enable = skew_reg[`BIT_ENABLE];
	wire dot_half_divider_n = skew_reg[`BIT_SELECT];
	wire slicer_mult_enable = slicer_reg[`BIT_ENABLE];
	wire slicer_prescale_half = slicer_reg[`BIT_SELECT];
	wire video_field_rate_select = slicer_reg[`BIT_VIDEO_MODE];

	// decode a page offset into a one-hot register pick; zero means not ours
	function [3:0] page_decode;
		input [7:0] addr;
		begin
			case (addr)
				`OFS_PIXEL_GATE: begin
					page_decode = 4'h1;
				end
				`OFS_SLICER: begin
					page_decode = 4'h2;
				end
				`OFS_CORE: begin
					page_decode = 4'h4;
				end
				`OFS_SKEW: begin
					page_decode = 4'h8;
				end
				default: begin
					// other page addresses belong to other blocks
					page_decode = 4'h0;
				end
			endcase
		end
	endfunction

	// keep only the writable bits, so reserved bits can never be stored
	function [7:0] keep_writable;
		input [7:0] data;
		input [7:0] mask;
		begin
			keep_writable = data & mask;
		end
	endfunction

	// pick the register that a one-hot decode names; nothing picked reads zero
	function [7:0] read_pick;
		input [3:0] hit;
		input [7:0] core_val;
		input [7:0] skew_val;
		input [7:0] pixel_val;
		input [7:0] slicer_val;
		begin
			case (hit)
				4'h1: begin
					read_pick = pixel_val;
				end
				4'h2: begin
					read_pick = slicer_val;
				end
				4'h4: begin
					read_pick = core_val;
				end
				4'h8: begin
					read_pick = skew_val;
				end
				default: begin
					// unmapped offset
					read_pick = 8'h00;
				end
			endcase
		end
	endfunction

	// address decode shared by the write and read paths
	assign page_hit = page_decode(REG_ADDR);
	assign pixel_wr = REG_WR & page_hit[0];
	assign slicer_wr = REG_WR & page_hit[1];
	assign core_wr = REG_WR & page_hit[2];
	assign skew_wr = REG_WR & page_hit[3];

	// core register next value; halt beats a write in the same cycle
	always @* begin
		core_next = core_reg; // hold by default
		if (HALT_ENTRY) begin
			// halt drops the multiplier and puts the cpu back on the crystal
			core_next = `RST_CORE;
		end else if (core_wr) begin
			// reserved bits 5:4 are never stored
			core_next = keep_writable(REG_WDATA, `MASK_CORE);
		end else begin
			// no access this cycle
			core_next = core_reg;
		end
	end

	// skew register next value; halt beats a write in the same cycle
	always @* begin
		skew_next = skew_reg; // hold by default
		if (HALT_ENTRY) begin
			// halt stops the dot clock loop
			skew_next = `RST_SKEW;
		end else if (skew_wr) begin
			// enable, bypass and factor only
			skew_next = keep_writable(REG_WDATA, `MASK_SKEW);
		end else begin
			// no access this cycle
			skew_next = skew_reg;
		end
	end

	// pixel gate next value; halt leaves it alone, only the loops are stopped
	always @* begin
		pixel_next = pixel_reg; // hold by default
		if (pixel_wr) begin
			// only the gate bit exists
			pixel_next = keep_writable(REG_WDATA, `MASK_PIXEL_GATE);
		end else begin
			// no access this cycle
			pixel_next = pixel_reg;
		end
	end

	// slicer register next value; halt beats a write in the same cycle
	always @* begin
		slicer_next = slicer_reg; // hold by default
		if (HALT_ENTRY) begin
			// halt stops the slicer loop and returns to 50 Hz slicing
			slicer_next = `RST_SLICER;
		end else if (slicer_wr) begin
			// enable, prescale and video mode only
			slicer_next = keep_writable(REG_WDATA, `MASK_SLICER);
		end else begin
			// no access this cycle
			slicer_next = slicer_reg;
		end
	end

	// read source, looked up before the edge so the flop only captures
	always @* begin
		read_next = read_pick(page_hit, core_reg, skew_reg, pixel_reg, slicer_reg);
	end

	// register state; reset leaves multipliers disabled
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			core_reg <= `RST_CORE;
			skew_reg <= `RST_SKEW;
			pixel_reg <= `RST_PIXEL_GATE;
			slicer_reg <= `RST_SLICER;
		end else begin
			core_reg <= core_next;
			skew_reg <= skew_next;
			pixel_reg <= pixel_next;
			slicer_reg <= slicer_next;
		end
	end

	// read data registered one cycle after the read strobe; it stands until the next read
	// reads have no side effects, so a repeated read is always safe
	always @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			// nothing read yet
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			// capture the decoded register
			REG_RDATA <= read_next;
		end else begin
			// keep the last read value
			REG_RDATA <= REG_RDATA;
		end
	end

	// core steering: select only counts while the multiplier runs, guarding the cpu
	// a loop switched off with the select still set falls back to the crystal at once
	assign CORE_MULT_ON = core_mult_enable;
	assign CORE_USE_MULT = core_mult_enable & core_clock_select;
	// dot and pixel paths
	assign DOT_MULT_ON = dot_mult_enable;
	assign DOT_HALF_BYPASS = dot_half_divider_n;
	assign PIXEL_CLOCK_PASS = pixel_reg[`BIT_ENABLE];
	// slicer path: fixed ratios, only the prescale choice moves
	// the multiply factor is a constant because no other setting is allowed
	assign SLICER_MULT_ON = slicer_mult_enable;
	assign LABEL_SLICER_CLOCK_ON = slicer_mult_enable & LABEL_SLICER_EN;
	assign SLICER_MULT_FACTOR = `SLICER_MULT;
	assign SLICER_PRESCALE = slicer_prescale_half ? `SLICER_PRESCALE_8M : `SLICER_PRESCALE_4M;
	assign VIDEO_60HZ = video_field_rate_select;
	assign BYTES_PER_LINE = video_field_rate_select ? `BYTES_PER_LINE_60 : `BYTES_PER_LINE_50;

	// ratio arithmetic
	clock_ratio_calc ratio_u (
		.core_factor(core_reg[`FACTOR_MSB:0]),
		.dot_factor(skew_reg[`FACTOR_MSB:0]),
		.dot_bypass(dot_half_divider_n),
		.core_ratio_x2(CORE_RATIO_X2),
		.dot_ratio(DOT_RATIO),
		.dot_out_ratio_x2(DOT_OUT_RATIO_X2)
	);
endmodule

// *** bench/timing_clock_multiplier_control_props.sv ***
// checker for the clock multiplier control block
`timescale 1ns/1ps
module clock_ctrl_props (
	input wire CLK,
	input wire RST_N,
	input wire HALT_ENTRY,
	input wire [7:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire LABEL_SLICER_EN,
	input wire CORE_MULT_ON,
	input wire CORE_USE_MULT,
	input wire [4:0] CORE_RATIO_X2,
	input wire DOT_HALF_BYPASS,
	input wire [4:0] DOT_RATIO,
	input wire [5:0] DOT_OUT_RATIO_X2,
	input wire SLICER_MULT_ON,
	input wire LABEL_SLICER_CLOCK_ON,
	input wire [7:0] SLICER_PRESCALE,
	input wire VIDEO_60HZ,
	input wire [5:0] BYTES_PER_LINE
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);
	// a core write that halt does not override
	sequence s_core_wr;
		REG_WR && !HALT_ENTRY && REG_ADDR == 8'h00FD;
	endsequence
	a_select_needs_enable: assert property (CORE_USE_MULT |-> CORE_MULT_ON) else $error("select without enable");
	a_core_ratio_wr: assert property (s_core_wr |=> CORE_RATIO_X2 == $past(REG_WDATA[3:0]) + 5'h01)
		else $error("core ratio wrong");
	a_halt_clears: assert property (HALT_ENTRY |=> !CORE_MULT_ON && !SLICER_MULT_ON && CORE_RATIO_X2 == 5'h01)
		else $error("halt left a multiplier on");
	a_reset_off: assert property ($rose(RST_N) |-> !CORE_MULT_ON && !CORE_USE_MULT) else $error("multiplier on");
	a_dot_divide: assert property (DOT_OUT_RATIO_X2 == (DOT_HALF_BYPASS ? {DOT_RATIO, 1'b0} : {1'b0, DOT_RATIO}))
		else $error("dot divider wrong");
	a_label_gate: assert property (LABEL_SLICER_CLOCK_ON == (SLICER_MULT_ON && LABEL_SLICER_EN)) else $error("label");
	a_prescale_set: assert property (SLICER_PRESCALE == 8'h0040 || SLICER_PRESCALE == 8'h0080) else $error("prescale");
	a_line_bytes: assert property (BYTES_PER_LINE == (VIDEO_60HZ ? 6'h0021 : 6'h0029)) else $error("line bytes");
endmodule
bind timing_clock_multiplier_control clock_ctrl_props props (.*);

// *** bench/timing_clock_multiplier_control_test.sv ***
// self-checking bench for the clock multiplier control block
`timescale 1ns/1ps
module timing_clock_multiplier_control_test;
	logic CLK = 0, RST_N = 0, HALT_ENTRY = 0, REG_WR = 0, REG_RD = 0, LABEL_SLICER_EN = 1;
	logic [7:0] REG_ADDR = 8'h0000, REG_WDATA = 8'h0000, REG_RDATA, SLICER_PRESCALE;
	logic CORE_MULT_ON, CORE_USE_MULT, DOT_MULT_ON, DOT_HALF_BYPASS, PIXEL_CLOCK_PASS, SLICER_MULT_ON;
	logic LABEL_SLICER_CLOCK_ON, VIDEO_60HZ;
	logic [4:0] CORE_RATIO_X2, DOT_RATIO;
	logic [5:0] DOT_OUT_RATIO_X2, BYTES_PER_LINE;
	logic [9:0] SLICER_MULT_FACTOR;
	int err_total = 0, n_compared = 0;
	logic [7:0] map [4] = '{8'h00FB, 8'h00FC, 8'h00FD, 8'h00FE}; // page offsets
	logic [7:0] init [4] = '{8'h00FF, 8'h00FF, 8'h003B, 8'h003B}; // factors 11, core and skew enables clear
	logic [7:0] keep [4] = '{8'h0080, 8'h00D0, 8'h000B, 8'h000B}; // writable bits only
	timing_clock_multiplier_control dut (.*);
	// clock, inputs change on its falling edge
	initial forever #50 CLK = ~CLK;
	task chk(input string nm, input logic [9:0] s, input logic [9:0] e);
		n_compared++;
		if (s !== e) begin
			err_total++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge CLK);
		REG_ADDR = a;
		REG_WDATA = d;
		REG_WR = 1;
		@(negedge CLK);
		REG_WR = 0;
	endtask
	// read data is registered, so it is looked at one cycle on
	task rd(input logic [7:0] a, input logic [7:0] e);
		@(negedge CLK);
		REG_ADDR = a;
		REG_RD = 1;
		@(negedge CLK);
		REG_RD = 0;
		chk("read data", REG_RDATA, e);
	endtask
	task complete_run;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge CLK);
		RST_N = 1;
		for (int i = 0; i < 4; i++) rd(map[i], 8'h0000);
		chk("core path", CORE_USE_MULT, 0);
		// factors go in first with the core and dot enables clear; reserved bits written high
		for (int i = 0; i < 4; i++) begin
			wr(map[i], init[i]);
			rd(map[i], keep[i]);
		end
		wr(8'h00FD, 8'h008B);
		// settle wait kept short; the block holds no settle count of its own
		repeat (20) @(negedge CLK);
		wr(8'h00FD, 8'h00FB);
		rd(8'h00FD, 8'h00CB);
		wr(8'h00FE, 8'h00FB);
		rd(8'h00FE, 8'h00CB);
		chk("core ratio", CORE_RATIO_X2, 12);
		chk("core path", CORE_USE_MULT, 1);
		chk("dot out", DOT_OUT_RATIO_X2, 24);
		chk("pixel gate", PIXEL_CLOCK_PASS, 1);
		chk("slicer on", {SLICER_MULT_ON, LABEL_SLICER_CLOCK_ON, VIDEO_60HZ}, 7);
		chk("prescale", SLICER_PRESCALE, 128);
		chk("line bytes", BYTES_PER_LINE, 33);
		chk("multiply", SLICER_MULT_FACTOR, 777);
		LABEL_SLICER_EN = 0;
		wr(8'h00FD, 8'h0040);
		wr(8'h00FE, 8'h0089);
		wr(8'h00FC, 8'h0080);
		chk("core path", {CORE_MULT_ON, CORE_USE_MULT}, 0);
		chk("dot out", {DOT_MULT_ON, DOT_OUT_RATIO_X2}, 10'h004A);
		chk("label clock", LABEL_SLICER_CLOCK_ON, 0);
		chk("line bytes", BYTES_PER_LINE, 41);
		wr(8'h00FF, 8'h00FF);
		rd(8'h00FF, 8'h0000);
		// halt held across a core write must still win
		HALT_ENTRY = 1;
		wr(8'h00FD, 8'h00FF);
		HALT_ENTRY = 0;
		for (int i = 0; i < 4; i++) rd(map[i], i == 0 ? 8'h0080 : 8'h0000);
		complete_run;
	end
endmodule
